// file: region_guard_pkg.sv
// constants and types shared by the region protection checker
// assumes a 32-bit address space and an apb register slave
package region_guard_pkg;

  localparam int unsigned NUM_REGIONS = 8;
  localparam int unsigned ADDR_W = 32;
  localparam int unsigned SUBREGIONS = 8;

  // register byte offsets
  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_COUNT = 12'h004;
  localparam logic [11:0] OFS_SELECT = 12'h008;
  localparam logic [11:0] OFS_BASE = 12'h00C;
  localparam logic [11:0] OFS_ATTR = 12'h010;
  localparam logic [11:0] OFS_STATUS = 12'h014;
  localparam logic [11:0] OFS_CLEAR = 12'h018;
  localparam logic [11:0] OFS_IRQ_EN = 12'h01C;
  localparam logic [11:0] OFS_FAULT_ADDR = 12'h020;

  // control bits
  localparam int unsigned CTRL_ENABLE = 0;
  localparam int unsigned CTRL_PRIV_BG = 1;
  localparam int unsigned CTRL_FAULT_CHK = 2;
  localparam int unsigned CTRL_W = 3;

  // attribute word layout
  localparam int unsigned ATTR_ON = 0;
  localparam int unsigned ATTR_SIZE_LO = 1;
  localparam int unsigned ATTR_SIZE_W = 5;
  localparam int unsigned ATTR_SRD_LO = 8;
  localparam int unsigned ATTR_PERM_LO = 24;
  localparam int unsigned ATTR_PERM_W = 3;
  localparam int unsigned ATTR_XN = 28;
  localparam logic [31:0] ATTR_MASK = 32'h17FFFF3F;

  // size code n means 2^(n+1) bytes; 4 is 32 bytes, 31 is 4 gigabytes
  localparam logic [4:0] size_code_smallest = 5'h04;
  localparam logic [4:0] size_code_largest = 5'h1F;
  localparam logic [4:0] SIZE_CODE_256 = 5'h07;

  // permission encodings
  localparam logic [2:0] perm_none_none = 3'h0;
  localparam logic [2:0] perm_rw_none = 3'h1;
  localparam logic [2:0] perm_rw_ro = 3'h2;
  localparam logic [2:0] perm_rw_rw = 3'h3;
  localparam logic [2:0] perm_ro_none = 3'h5;
  localparam logic [2:0] perm_ro_ro = 3'h6;

  // sticky event bits
  localparam int unsigned EV_FAULT = 0;
  localparam int unsigned EV_OVERRUN = 1;
  localparam int unsigned EV_W = 2;

  typedef enum logic [1:0] {
    acc_fetch,
    acc_read,
    acc_write
  } access_kind_t;

endpackage : region_guard_pkg

// file: region_match.sv
// one protection region: address match and permission verdict
// assumes attribute and base words as stored by the checker top
`timescale 1ns/1ps
module region_match
  import region_guard_pkg::*;
(
  input wire logic [31:0] base,
  input wire logic [31:0] attr,
  input wire logic [31:0] addr,
  input wire logic [1:0] kind,
  input wire logic privileged,
  output logic hit,
  output logic allowed
);

  logic [4:0] size_code;
  logic [32:0] span;
  logic [32:0] mask;
  logic in_region;
  logic [2:0] sub_idx;
  logic sub_off;
  logic [2:0] perm;
  logic rd_ok;
  logic wr_ok;

  always_comb begin
    size_code = attr[ATTR_SIZE_LO +: ATTR_SIZE_W];
    if (size_code < size_code_smallest) begin
      size_code = size_code_smallest;
    end
    // six-bit shift count so the 4 gigabyte code does not wrap to zero
    span = 33'h1 << (6'(size_code) + 6'h01);
    mask = span - 33'h1;
    in_region = ((addr & ~mask[31:0]) == (base & ~mask[31:0]));
    // top three bits within the region pick the sub-region
    sub_idx = 3'(({1'b0, addr} & mask) >> (size_code - 5'h02));
    sub_off = (size_code >= SIZE_CODE_256) && attr[ATTR_SRD_LO + sub_idx];
    hit = attr[ATTR_ON] && in_region && !sub_off;
    perm = attr[ATTR_PERM_LO +: ATTR_PERM_W];
    rd_ok = 1'b0;
    wr_ok = 1'b0;
    case (perm)
      perm_rw_none: begin
        rd_ok = privileged;
        wr_ok = privileged;
      end
      perm_rw_ro: begin
        rd_ok = 1'b1;
        wr_ok = privileged;
      end
      perm_rw_rw: begin
        rd_ok = 1'b1;
        wr_ok = 1'b1;
      end
      perm_ro_none: begin
        rd_ok = privileged;
      end
      perm_ro_ro: begin
        rd_ok = 1'b1;
      end
      default: begin
        rd_ok = 1'b0;
      end
    endcase
    case (kind)
      2'(acc_fetch): allowed = rd_ok && !attr[ATTR_XN];
      2'(acc_read): allowed = rd_ok;
      2'(acc_write): allowed = wr_ok;
      default: allowed = 1'b0;
    endcase
  end

endmodule : region_match

// file: region_guard.sv
// region protection checker with apb register slave and fault interrupt
// assumes the core presents one access per cycle, synchronous to clk
`timescale 1ns/1ps

module region_guard
  import region_guard_pkg::*;
#(
  parameter int unsigned REGIONS = region_guard_pkg::NUM_REGIONS
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic acc_valid,
  input wire logic [31:0] acc_addr,
  input wire logic [1:0] acc_kind,
  input wire logic acc_privileged,
  input wire logic acc_in_fault_handler,
  output logic fault,
  output logic irq
);
  import region_guard_pkg::*;

  if (REGIONS < 1 || REGIONS > NUM_REGIONS) begin : g_bad_regions
    $error("region count out of range");
  end

  // ---------------------------------------------
  // reset release
  // ---------------------------------------------
  logic rst_meta_ff;
  logic rst_sync_ff;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end

  // ---------------------------------------------
  // region matching
  // ---------------------------------------------
  logic [31:0] base_ff [REGIONS];
  logic [31:0] attr_ff [REGIONS];
  logic [REGIONS-1:0] hit;
  logic [REGIONS-1:0] allowed;

  for (genvar g = 0; g < REGIONS; g++) begin : g_region
    region_match u_match (
      .base(base_ff[g]),
      .attr(attr_ff[g]),
      .addr(acc_addr),
      .kind(acc_kind),
      .privileged(acc_privileged),
      .hit(hit[g]),
      .allowed(allowed[g])
    );
  end

  logic [CTRL_W-1:0] ctrl_ff;
  logic violation;
  logic any_hit;
  logic win_ok;

  always_comb begin
    any_hit = 1'b0;
    win_ok = 1'b0;
    for (int i = 0; i < REGIONS; i++) begin
      if (hit[i]) begin
        any_hit = 1'b1;
        win_ok = allowed[i];
      end
    end
    violation = 1'b0;
    if (acc_valid && ctrl_ff[CTRL_ENABLE]) begin
      if (acc_in_fault_handler && !ctrl_ff[CTRL_FAULT_CHK]) begin
        violation = 1'b0;
      end else if (any_hit) begin
        violation = !win_ok;
      end else begin
        violation = !(acc_privileged && ctrl_ff[CTRL_PRIV_BG]);
      end
    end
  end

  // ---------------------------------------------
  // apb register file
  // ---------------------------------------------
  function automatic logic is_reg(input logic [11:0] a, input logic [11:0] ofs);
    is_reg = (a == ofs);
  endfunction : is_reg

  logic [2:0] sel_ff;
  logic [2:0] nxt_sel;
  logic [CTRL_W-1:0] nxt_ctrl;
  logic [31:0] nxt_base [REGIONS];
  logic [31:0] nxt_attr [REGIONS];
  logic [EV_W-1:0] status_ff;
  logic [EV_W-1:0] nxt_status;
  logic [EV_W-1:0] irq_en_ff;
  logic [EV_W-1:0] nxt_irq_en;
  logic [31:0] fault_addr_ff;
  logic [31:0] nxt_fault_addr;
  logic [31:0] nxt_prdata;
  logic nxt_pready;
  logic nxt_pslverr;
  logic nxt_fault;
  logic nxt_irq;
  logic fault_ff;
  logic irq_ff;
  logic setup;
  logic wr;
  logic known;
  logic [EV_W-1:0] ev_set;

  assign setup = psel && !penable;

  always_comb begin
    nxt_sel = sel_ff;
    nxt_ctrl = ctrl_ff;
    nxt_base = base_ff;
    nxt_attr = attr_ff;
    nxt_irq_en = irq_en_ff;
    nxt_fault_addr = fault_addr_ff;
    nxt_prdata = 32'h00000000;
    nxt_pslverr = 1'b0;
    // answer in the access phase: one wait-free cycle
    nxt_pready = setup;
    wr = setup && pwrite;
    known = is_reg(paddr, OFS_CTRL) || is_reg(paddr, OFS_COUNT) || is_reg(paddr, OFS_SELECT)
      || is_reg(paddr, OFS_BASE) || is_reg(paddr, OFS_ATTR) || is_reg(paddr, OFS_STATUS)
      || is_reg(paddr, OFS_CLEAR) || is_reg(paddr, OFS_IRQ_EN) || is_reg(paddr, OFS_FAULT_ADDR);
    if (setup && !known) begin
      nxt_pslverr = 1'b1;
    end
    if (wr) begin
      if (is_reg(paddr, OFS_CTRL)) begin
        nxt_ctrl = pwdata[CTRL_W-1:0];
      end
      if (is_reg(paddr, OFS_SELECT)) begin
        nxt_sel = pwdata[2:0];
      end
      if (is_reg(paddr, OFS_BASE) && 32'(sel_ff) < REGIONS) begin
        nxt_base[sel_ff] = pwdata;
      end
      if (is_reg(paddr, OFS_ATTR) && 32'(sel_ff) < REGIONS) begin
        nxt_attr[sel_ff] = pwdata & ATTR_MASK;
      end
      if (is_reg(paddr, OFS_IRQ_EN)) begin
        nxt_irq_en = pwdata[EV_W-1:0];
      end
    end else if (setup) begin
      if (is_reg(paddr, OFS_CTRL)) begin
        nxt_prdata = 32'(ctrl_ff);
      end
      if (is_reg(paddr, OFS_COUNT)) begin
        nxt_prdata = 32'(REGIONS);
      end
      if (is_reg(paddr, OFS_SELECT)) begin
        nxt_prdata = 32'(sel_ff);
      end
      if (is_reg(paddr, OFS_BASE) && 32'(sel_ff) < REGIONS) begin
        nxt_prdata = base_ff[sel_ff];
      end
      if (is_reg(paddr, OFS_ATTR) && 32'(sel_ff) < REGIONS) begin
        nxt_prdata = attr_ff[sel_ff];
      end
      if (is_reg(paddr, OFS_STATUS)) begin
        nxt_prdata = 32'(status_ff);
      end
      if (is_reg(paddr, OFS_IRQ_EN)) begin
        nxt_prdata = 32'(irq_en_ff);
      end
      if (is_reg(paddr, OFS_FAULT_ADDR)) begin
        nxt_prdata = fault_addr_ff;
      end
    end
    // events; a set in the same cycle as a clear wins
    ev_set = '0;
    ev_set[EV_FAULT] = violation;
    ev_set[EV_OVERRUN] = violation && status_ff[EV_FAULT];
    nxt_status = status_ff;
    if (wr && is_reg(paddr, OFS_CLEAR)) begin
      nxt_status = status_ff & ~pwdata[EV_W-1:0];
    end
    nxt_status = nxt_status | ev_set;
    // first fault address is kept until its flag is cleared
    if (violation && !status_ff[EV_FAULT]) begin
      nxt_fault_addr = acc_addr;
    end
    nxt_fault = violation;
    nxt_irq = |(nxt_status & nxt_irq_en);
  end

  always_ff @(posedge clk or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      sel_ff <= '0;
      ctrl_ff <= '0;
      for (int i = 0; i < REGIONS; i++) begin
        base_ff[i] <= '0;
        attr_ff[i] <= '0;
      end
      status_ff <= '0;
      irq_en_ff <= '0;
      fault_addr_ff <= '0;
      prdata <= '0;
      pready <= 1'b0;
      pslverr <= 1'b0;
      fault_ff <= 1'b0;
      irq_ff <= 1'b0;
    end else begin
      sel_ff <= nxt_sel;
      ctrl_ff <= nxt_ctrl;
      base_ff <= nxt_base;
      attr_ff <= nxt_attr;
      status_ff <= nxt_status;
      irq_en_ff <= nxt_irq_en;
      fault_addr_ff <= nxt_fault_addr;
      prdata <= nxt_prdata;
      pready <= nxt_pready;
      pslverr <= nxt_pslverr;
      fault_ff <= nxt_fault;
      irq_ff <= nxt_irq;
    end
  end

  assign fault = fault_ff;
  assign irq = irq_ff;

endmodule : region_guard

// file: region_guard_properties.sv
// checker for the region guard top-level ports
// assumes binding onto region_guard; tracks control writes itself
`timescale 1ns/1ps
module region_guard_properties
  import region_guard_pkg::*;
#(
  parameter int unsigned REGIONS = NUM_REGIONS
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic acc_valid,
  input wire logic [31:0] acc_addr,
  input wire logic [1:0] acc_kind,
  input wire logic acc_privileged,
  input wire logic acc_in_fault_handler,
  input wire logic fault,
  input wire logic irq
);
  logic [2:0] ctrl_ff;
  logic [2:0] nxt_ctrl;
  logic setup;
  assign setup = psel && !penable;
  // write lands at the setup edge, as the slave does
  always_comb begin
    nxt_ctrl = ctrl_ff;
    if (setup && pwrite && paddr == OFS_CTRL) begin
      nxt_ctrl = pwdata[2:0];
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_ff <= 3'h0;
    end else begin
      ctrl_ff <= nxt_ctrl;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_ready_next: assert property (setup |=> pready && penable) else $error("no ready");
  a_ready_pulse: assert property (pready |=> !pready) else $error("ready too long");
  a_ready_cause: assert property (pready |-> $past(setup)) else $error("stray ready");
  a_err_unmapped: assert property (setup && paddr > OFS_FAULT_ADDR |=> pslverr)
    else $error("no slave error");
  a_err_ready: assert property (pslverr |-> pready) else $error("lone slave error");
  a_rdata_idle: assert property (!pready |-> prdata == 32'h0) else $error("idle data");
  a_count_value: assert property (setup && !pwrite && paddr == OFS_COUNT |=>
    prdata == REGIONS) else $error("bad count");
  a_fault_cause: assert property (fault |-> $past(acc_valid) && $past(ctrl_ff[0]))
    else $error("stray fault");
  a_off_quiet: assert property (acc_valid && (!ctrl_ff[0] ||
    (acc_in_fault_handler && !ctrl_ff[2])) |=> !fault) else $error("fault while off");
endmodule : region_guard_properties

// file: core_model.sv
// core model issuing one access at a time
// assumes the bench calls issue from its main sequence
`timescale 1ns/1ps
module core_model (
  input wire logic clk,
  output logic acc_valid,
  output logic [31:0] acc_addr,
  output logic [1:0] acc_kind,
  output logic acc_privileged,
  output logic acc_in_fault_handler
);
  initial begin
    acc_valid = 1'b0;
    acc_addr = 32'h0;
    acc_kind = 2'h0;
    acc_privileged = 1'b0;
    acc_in_fault_handler = 1'b0;
  end
  task issue(input logic [31:0] a, input logic [1:0] k, input logic p, input logic h);
    @(posedge clk);
    acc_valid <= 1'b1;
    acc_addr <= a;
    acc_kind <= k;
    acc_privileged <= p;
    acc_in_fault_handler <= h;
    @(posedge clk);
    acc_valid <= 1'b0;
    // idle address inverted so a stale value is never taken as real
    acc_addr <= ~a;
  endtask : issue
endmodule : core_model

// file: tb_top.sv
// bench for the region guard: apb tasks plus core accesses
// assumes core_model drives the access port
`timescale 1ns/1ps
module tb_top;
  import region_guard_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd, acc_addr;
  logic pready, pslverr, err, acc_valid, acc_privileged, acc_in_fault_handler, fault, irq;
  logic [1:0] acc_kind;
  int error_cnt = 0;
  int compares = 0;
  always #50 clk = ~clk;
  region_guard uut (.clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .acc_valid, .acc_addr, .acc_kind, .acc_privileged,
    .acc_in_fault_handler, .fault, .irq);
  core_model core (.clk, .acc_valid, .acc_addr, .acc_kind, .acc_privileged,
    .acc_in_fault_handler);
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s exp %h got %h", n, e, g);
    end
  endtask : chk
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task rdc(input string n, input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(n, e, rd);
  endtask : rdc
  function automatic logic [31:0] at(logic on, logic [4:0] c, logic [7:0] s, logic [2:0] p,
    logic x);
    return {3'h0, x, 1'b0, p, 8'h00, s, 2'h0, c, on};
  endfunction : at
  task rgn(input logic [2:0] i, input logic [31:0] b, input logic [31:0] t);
    apb(1'b1, OFS_SELECT, {29'h0, i});
    apb(1'b1, OFS_BASE, b);
    apb(1'b1, OFS_ATTR, t);
    rdc("base", OFS_BASE, b);
    rdc("attr", OFS_ATTR, t);
  endtask : rgn
  task acc(input logic [31:0] a, input logic [1:0] k, input logic p, input logic h,
    input logic e);
    core.issue(a, k, p, h);
    @(negedge clk);
    chk("fault", {31'h0, e}, 32'(fault));
  endtask : acc
  task final_report;
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : final_report
  initial begin
    #500000;
    error_cnt++;
    final_report();
  end
  // ----------------
  // main sequence
  // ----------------
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    rdc("count", OFS_COUNT, 32'(NUM_REGIONS));
    apb(1'b0, 12'h024, 32'h0);
    chk("unmapped", 32'h1, 32'(err));
    // regions set up while the unit is off, so none is half-built when checked
    rgn(0, 32'h0000_1000, at(1, 5'h0B, 8'h00, perm_ro_ro, 1));
    rgn(3, 32'h0000_1000, at(0, 5'h0B, 8'h00, perm_rw_rw, 0));
    rgn(1, 32'h0000_2000, at(1, 5'h07, 8'h01, perm_rw_rw, 0));
    rgn(7, 32'h0000_3000, at(1, 5'h06, 8'hFF, perm_rw_rw, 0));
    rgn(4, 32'h0000_1000, at(1, size_code_smallest, 8'h00, perm_rw_rw, 0));
    rgn(5, 32'h0000_0000, at(0, size_code_largest, 8'h00, perm_rw_none, 0));
    acc(32'h0000_1800, acc_write, 0, 0, 0);
    apb(1'b1, OFS_CTRL, 32'h1);
    acc(32'h0000_1800, acc_write, 1, 0, 1);
    acc(32'h0000_1800, acc_read, 0, 0, 0);
    acc(32'h0000_1800, acc_fetch, 1, 0, 1);
    acc(32'h0000_1004, acc_write, 0, 0, 0);
    acc(32'h0000_1020, acc_write, 0, 0, 1);
    acc(32'h0000_2000, acc_read, 0, 0, 1);
    acc(32'h0000_2020, acc_read, 0, 0, 0);
    acc(32'h0000_3000, acc_read, 0, 0, 0);
    acc(32'h0000_9000, acc_read, 1, 0, 1);
    acc(32'h0000_9000, acc_write, 1, 1, 0);
    apb(1'b1, OFS_CTRL, 32'h7);
    acc(32'h0000_9000, acc_read, 1, 0, 0);
    acc(32'h0000_9000, acc_read, 0, 1, 1);
    rgn(5, 32'h0000_0000, at(1, size_code_largest, 8'h00, perm_ro_none, 0));
    acc(32'hF000_0000, acc_write, 1, 0, 1);
    acc(32'h8000_0000, acc_read, 1, 0, 0);
    rdc("status", OFS_STATUS, 32'h3);
    rdc("fault addr", OFS_FAULT_ADDR, 32'h0000_1800);
    chk("irq masked", 32'h0, 32'(irq));
    apb(1'b1, OFS_IRQ_EN, 32'h1);
    @(negedge clk);
    chk("irq", 32'h1, 32'(irq));
    apb(1'b1, OFS_CLEAR, 32'h3);
    @(negedge clk);
    chk("irq cleared", 32'h0, 32'(irq));
    rdc("status clr", OFS_STATUS, 32'h0);
    final_report();
  end
endmodule : tb_top
bind region_guard region_guard_properties #(.REGIONS(REGIONS)) props (.clk, .rst_n, .psel,
  .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .acc_valid, .acc_addr,
  .acc_kind, .acc_privileged, .acc_in_fault_handler, .fault, .irq);
